// >>> rtl/pwmbs_pkg.sv
// constants shared by the pwm timer write-buffer synchronisation block
package pwmbs_pkg;
  // =========================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_SYNC  = 8'h04;
  localparam logic [7:0] OFS_MOD   = 8'h08;
  localparam logic [7:0] OFS_INIT  = 8'h0c;
  localparam logic [7:0] OFS_MASK  = 8'h10;
  localparam logic [7:0] OFS_CHCFG = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  localparam logic [7:0] OFS_CHV   = 8'h20;
  localparam logic [7:0] CHV_STEP  = 8'h04;

  // =========================================
  // control register fields
  localparam int CLK_SRC_LSB = 0;
  localparam int EXT_EN_BIT  = 2;
  localparam int CENTER_BIT  = 3;

  // =========================================
  // sync register fields
  localparam int TRIG_LSB     = 0;
  localparam int SW_REQ_BIT   = 3;
  localparam int BND_MIN_BIT  = 4;
  localparam int BND_MAX_BIT  = 5;
  localparam int SYNC_MODE_BIT = 6;
  localparam int IMMEDIATE_A_BIT   = 7;
  localparam int MASK_SYNC_BIT = 8;

  // =========================================
  // channel config fields
  localparam int OC_LSB     = 0;
  localparam int CH_SYNC_LSB = 8;

  // =========================================
  // counts and reset values
  localparam int          NTRIG       = 3;
  localparam int          NSLOT_FIXED = 2;
  localparam logic [1:0]  CLK_STOPPED = 2'h0;
  localparam logic [15:0] VALUE_RST   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : pwmbs_pkg

// >>> rtl/pwmbs_sync.sv
// pwm timer write-buffer update and synchronisation with an axi4-lite register slave
`timescale 1ns/1ns
module pwmbs_sync #(
  parameter int NCH = 8
) (
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire logic [7:0]           S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output wire logic                 S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output wire logic                 S_AXI_WREADY,
  output wire logic [1:0]           S_AXI_BRESP,
  output wire logic                 S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [7:0]           S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output wire logic                 S_AXI_ARREADY,
  output wire logic [31:0]          S_AXI_RDATA,
  output wire logic [1:0]           S_AXI_RRESP,
  output wire logic                 S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  input  wire logic [2:0]           TRIG_IN,
  input  wire logic                 CNT_TICK,
  input  wire logic                 CNT_WRAP,
  input  wire logic                 CNT_PEAK_STEP,
  input  wire logic                 CNT_MIN_STEP,
  input  wire logic                 CNT_MAX_STEP,
  output wire logic [15:0]          MOD_VALUE,
  output wire logic [15:0]          INIT_VALUE,
  output wire logic [NCH*16-1:0]    CH_VALUE,
  output wire logic [NCH-1:0]       OUT_MASK,
  output wire logic                 CNT_IMMEDIATE_A,
  output wire logic [1:0]           CLK_SOURCE,
  output wire logic                 CENTER_MODE
);
  localparam int NB = NCH + pwmbs_pkg::NSLOT_FIXED;

  function automatic logic [7:0] slot_adr(input int k);
    logic [7:0] ad;
    if (k == 0) begin
      ad = pwmbs_pkg::OFS_MOD;
    end else if (k == 1) begin
      ad = pwmbs_pkg::OFS_INIT;
    end else begin
      ad = 8'(pwmbs_pkg::OFS_CHV + pwmbs_pkg::CHV_STEP * (k - 2));
    end
    return ad;
  endfunction : slot_adr

  function automatic logic addr_ok(input logic [7:0] ad);
    logic ok;
    ok = ad inside {pwmbs_pkg::OFS_CTRL, pwmbs_pkg::OFS_SYNC, pwmbs_pkg::OFS_MASK,
                    pwmbs_pkg::OFS_CHCFG, pwmbs_pkg::OFS_STAT};
    for (int k = 0; k < NB; k++) begin
      if (ad == slot_adr(k)) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction : addr_ok

  // =========================================
  // axi write channel
  logic        awrdy_reg;
  logic        wrdy_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_go;
  logic        wlo;
  logic        whi;

  // address and data are taken in either order; the answer follows both
  assign wr_go = !awrdy_reg && !wrdy_reg && !bvalid_reg;
  assign wlo   = wstrb_reg[0];
  assign whi   = wstrb_reg[1];

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      awrdy_reg  <= 1'b1;
      awaddr_reg <= 8'h00;
    end else if (S_AXI_AWVALID && awrdy_reg) begin
      awrdy_reg  <= 1'b0;
      awaddr_reg <= S_AXI_AWADDR;
    end else if (wr_go) begin
      awrdy_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wrdy_reg  <= 1'b1;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (S_AXI_WVALID && wrdy_reg) begin
      wrdy_reg  <= 1'b0;
      wdata_reg <= S_AXI_WDATA;
      wstrb_reg <= S_AXI_WSTRB;
    end else if (wr_go) begin
      wrdy_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= pwmbs_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= addr_ok(awaddr_reg) ? pwmbs_pkg::RESP_OKAY : pwmbs_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  logic w_ctrl;
  logic w_sync;
  logic w_mask;
  logic w_chcfg;
  assign w_ctrl  = wr_go && wlo && awaddr_reg == pwmbs_pkg::OFS_CTRL;
  assign w_sync  = wr_go && awaddr_reg == pwmbs_pkg::OFS_SYNC;
  assign w_mask  = wr_go && wlo && awaddr_reg == pwmbs_pkg::OFS_MASK;
  assign w_chcfg = wr_go && awaddr_reg == pwmbs_pkg::OFS_CHCFG;

  // =========================================
  // configuration registers
  logic [1:0]     clk_src_reg;
  logic           ext_en_reg;
  logic           center_reg;
  logic           bnd_min_reg;
  logic           bnd_max_reg;
  logic           sync_mode_reg;
  logic           immediate_a_reg;
  logic           mask_sync_reg;
  logic [NCH-1:0] oc_reg;
  logic [NCH-1:0] ch_sync_reg;
  logic [NCH-1:0] mask_buf_reg;
  logic [NCH-1:0] mask_act_reg;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      clk_src_reg <= pwmbs_pkg::CLK_STOPPED;
      ext_en_reg  <= 1'b0;
      center_reg  <= 1'b0;
    end else if (w_ctrl) begin
      clk_src_reg <= wdata_reg[pwmbs_pkg::CLK_SRC_LSB +: 2];
      ext_en_reg  <= wdata_reg[pwmbs_pkg::EXT_EN_BIT];
      center_reg  <= wdata_reg[pwmbs_pkg::CENTER_BIT];
    end
  end

  // boundary selects have no hardware clear path
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bnd_min_reg   <= 1'b0;
      bnd_max_reg   <= 1'b0;
      sync_mode_reg <= 1'b0;
      immediate_a_reg    <= 1'b0;
      mask_sync_reg <= 1'b0;
    end else if (w_sync) begin
      if (wlo) begin
        bnd_min_reg   <= wdata_reg[pwmbs_pkg::BND_MIN_BIT];
        bnd_max_reg   <= wdata_reg[pwmbs_pkg::BND_MAX_BIT];
        sync_mode_reg <= wdata_reg[pwmbs_pkg::SYNC_MODE_BIT];
        immediate_a_reg    <= wdata_reg[pwmbs_pkg::IMMEDIATE_A_BIT];
      end
      if (whi) begin
        mask_sync_reg <= wdata_reg[pwmbs_pkg::MASK_SYNC_BIT];
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      oc_reg      <= '0;
      ch_sync_reg <= '0;
    end else if (w_chcfg) begin
      if (wlo) begin
        oc_reg <= wdata_reg[pwmbs_pkg::OC_LSB +: NCH];
      end
      if (whi) begin
        ch_sync_reg <= wdata_reg[pwmbs_pkg::CH_SYNC_LSB +: NCH];
      end
    end
  end

  // =========================================
  // hardware triggers
  logic [2:0] trig_s1_reg;
  logic [2:0] trig_s2_reg;
  logic [2:0] trig_s3_reg;
  logic [2:0] trig_en_reg;
  logic [2:0] hw_ev;
  logic       hw_any;
  logic       w_sync_lo;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      trig_s1_reg <= 3'h0;
      trig_s2_reg <= 3'h0;
      trig_s3_reg <= 3'h0;
    end else begin
      trig_s1_reg <= TRIG_IN;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end

  assign w_sync_lo = w_sync && wlo;
  assign hw_ev     = trig_s2_reg & ~trig_s3_reg & trig_en_reg;
  assign hw_any    = |hw_ev;

  // the write is checked first so a coincident set keeps the enable
  generate
    for (genvar t = 0; t < pwmbs_pkg::NTRIG; t++) begin : g_trig
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          trig_en_reg[t] <= 1'b0;
        end else if (w_sync_lo) begin
          trig_en_reg[t] <= wdata_reg[pwmbs_pkg::TRIG_LSB + t];
        end else if (hw_ev[t]) begin
          trig_en_reg[t] <= 1'b0;
        end
      end
    end
  endgenerate

  // =========================================
  // software trigger and synchronisation timing
  logic running;
  logic imm;
  logic sw_req_reg;
  logic sw_pulse_reg;
  logic hw_arm_reg;
  logic bnd_hit;
  logic sync_load;
  logic sw_clr;
  logic mask_evt;
  logic cnt_immediate_a_reg;

  assign running = clk_src_reg != pwmbs_pkg::CLK_STOPPED;
  assign imm     = !sync_mode_reg && immediate_a_reg;
  // both selects set: whichever boundary pulse comes first loads
  assign bnd_hit = running && ((bnd_min_reg && (center_reg ? CNT_MIN_STEP : CNT_WRAP))
                 || (bnd_max_reg && CNT_MAX_STEP));
  // mode 1 never arms from hardware, so only software requests reach a boundary
  assign sync_load = imm ? (hw_any || sw_pulse_reg)
                   : (bnd_hit && (sw_req_reg || (hw_arm_reg && !sync_mode_reg)));
  assign sw_clr = imm ? sw_pulse_reg : (bnd_hit && sw_req_reg);
  assign mask_evt = hw_any || (!sync_mode_reg && sw_pulse_reg);

  // the trigger event is taken one cycle after the write of one
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sw_pulse_reg <= 1'b0;
    end else begin
      sw_pulse_reg <= w_sync_lo && wdata_reg[pwmbs_pkg::SW_REQ_BIT];
    end
  end

  // a write wins over the completion clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sw_req_reg <= 1'b0;
    end else if (w_sync_lo) begin
      sw_req_reg <= wdata_reg[pwmbs_pkg::SW_REQ_BIT];
    end else if (sw_clr) begin
      sw_req_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hw_arm_reg <= 1'b0;
    end else if (hw_any && !sync_mode_reg && !immediate_a_reg) begin
      hw_arm_reg <= 1'b1;
    end else if (bnd_hit) begin
      hw_arm_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_immediate_a_reg <= 1'b0;
    end else begin
      cnt_immediate_a_reg <= immediate_a_reg ? (hw_any || (!sync_mode_reg && sw_pulse_reg)) : CNT_WRAP;
    end
  end

  // =========================================
  // output mask
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mask_buf_reg <= '0;
    end else if (w_mask) begin
      mask_buf_reg <= wdata_reg[NCH-1:0];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mask_act_reg <= '0;
    end else if (!mask_sync_reg || mask_evt) begin
      mask_act_reg <= mask_buf_reg;
    end
  end

  // =========================================
  // buffered values: slot 0 modulo, slot 1 initial, then channels
  wire [NB-1:0] full_w;
  wire [NB-1:0] ld_w;
  wire [NB-1:0] wsel_w;
  wire [15:0]   wbuf_w [NB];
  wire [15:0]   act_w  [NB];

  generate
    for (genvar i = 0; i < NB; i++) begin : g_slot
      logic [15:0] wbuf_reg;
      logic [15:0] act_reg;
      logic        lo_reg;
      logic        hi_reg;
      logic        ld;
      logic        sel;

      assign sel       = wr_go && awaddr_reg == slot_adr(i);
      assign full_w[i] = lo_reg && hi_reg;
      assign ld_w[i]   = ld;
      assign wsel_w[i] = sel;
      assign wbuf_w[i] = wbuf_reg;
      assign act_w[i]  = act_reg;

      if (i == 0) begin : g_mod
        assign ld = full_w[i] && (!running
                  || (!ext_en_reg && (center_reg ? CNT_PEAK_STEP : CNT_WRAP))
                  || (ext_en_reg && sync_load));
      end else if (i == 1) begin : g_init
        assign ld = full_w[i];
      end else begin : g_ch
        logic own;
        assign own = !ext_en_reg || !ch_sync_reg[i-2];
        assign ld  = full_w[i] && (!running
                   || (own && oc_reg[i-2] && CNT_TICK)
                   || (own && !oc_reg[i-2] && (center_reg ? CNT_PEAK_STEP : CNT_WRAP))
                   || (!own && sync_load));
      end

      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          wbuf_reg <= pwmbs_pkg::VALUE_RST;
        end else if (sel) begin
          wbuf_reg[7:0]  <= wlo ? wdata_reg[7:0] : wbuf_reg[7:0];
          wbuf_reg[15:8] <= whi ? wdata_reg[15:8] : wbuf_reg[15:8];
        end
      end

      // a byte written in the transfer cycle keeps its flag
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          lo_reg <= 1'b0;
          hi_reg <= 1'b0;
        end else begin
          lo_reg <= (lo_reg && !ld) || (sel && wlo);
          hi_reg <= (hi_reg && !ld) || (sel && whi);
        end
      end

      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          act_reg <= pwmbs_pkg::VALUE_RST;
        end else if (ld) begin
          act_reg <= wbuf_reg;
        end
      end

      if (i >= 2) begin : g_out
        assign CH_VALUE[16*(i-2) +: 16] = act_reg;
      end
    end
  endgenerate

  // =========================================
  // axi read channel
  logic        arrdy_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_data;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (S_AXI_ARADDR)
      pwmbs_pkg::OFS_CTRL: begin
        rd_data[pwmbs_pkg::CLK_SRC_LSB +: 2] = clk_src_reg;
        rd_data[pwmbs_pkg::EXT_EN_BIT]       = ext_en_reg;
        rd_data[pwmbs_pkg::CENTER_BIT]       = center_reg;
      end
      pwmbs_pkg::OFS_SYNC: begin
        rd_data[pwmbs_pkg::TRIG_LSB +: 3]    = trig_en_reg;
        rd_data[pwmbs_pkg::SW_REQ_BIT]       = sw_req_reg;
        rd_data[pwmbs_pkg::BND_MIN_BIT]      = bnd_min_reg;
        rd_data[pwmbs_pkg::BND_MAX_BIT]      = bnd_max_reg;
        rd_data[pwmbs_pkg::SYNC_MODE_BIT]    = sync_mode_reg;
        rd_data[pwmbs_pkg::IMMEDIATE_A_BIT]       = immediate_a_reg;
        rd_data[pwmbs_pkg::MASK_SYNC_BIT]    = mask_sync_reg;
      end
      pwmbs_pkg::OFS_MASK: begin
        rd_data[NCH-1:0] = mask_act_reg;
      end
      pwmbs_pkg::OFS_CHCFG: begin
        rd_data[pwmbs_pkg::OC_LSB +: NCH]      = oc_reg;
        rd_data[pwmbs_pkg::CH_SYNC_LSB +: NCH] = ch_sync_reg;
      end
      pwmbs_pkg::OFS_STAT: begin
        rd_data[NB-1:0] = full_w;
      end
      default: begin
        for (int k = 0; k < NB; k++) begin
          if (S_AXI_ARADDR == slot_adr(k)) begin
            rd_data = {16'h0000, act_w[k]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      arrdy_reg  <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= pwmbs_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && arrdy_reg) begin
      arrdy_reg  <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_data;
      rresp_reg  <= addr_ok(S_AXI_ARADDR) ? pwmbs_pkg::RESP_OKAY : pwmbs_pkg::RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      arrdy_reg  <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = awrdy_reg;
  assign S_AXI_WREADY  = wrdy_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = arrdy_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign MOD_VALUE     = act_w[0];
  assign INIT_VALUE    = act_w[1];
  assign OUT_MASK      = mask_act_reg;
  assign CNT_IMMEDIATE_A    = cnt_immediate_a_reg;
  assign CLK_SOURCE    = clk_src_reg;
  assign CENTER_MODE   = center_reg;

  // =========================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  trig_clear_a: assert property (
    (hw_ev[0] && !w_sync_lo) |=> !trig_en_reg[0] ##1 (!trig_en_reg[0] || $past(w_sync_lo)))
    else $error("trigger enable not cleared by its event");
  trig_keep_a: assert property (
    (hw_ev[1] && w_sync_lo && wdata_reg[pwmbs_pkg::TRIG_LSB + 1]) |=> trig_en_reg[1])
    else $error("trigger enable lost on coincident write");
  sw_keep_a: assert property (
    (w_sync_lo && wdata_reg[pwmbs_pkg::SW_REQ_BIT]) |=> sw_req_reg && sw_pulse_reg)
    else $error("software request not held after write");
  stop_load_a: assert property (
    (!running && full_w[0] && !wsel_w[0]) |=> MOD_VALUE == $past(wbuf_w[0]) && !full_w[0])
    else $error("modulo not loaded while stopped");
  init_load_a: assert property (
    full_w[1] |=> INIT_VALUE == $past(wbuf_w[1]))
    else $error("initial value not loaded");
  no_bound_a: assert property (
    (running && ext_en_reg && !bnd_min_reg && !bnd_max_reg && !imm) |=> $stable(MOD_VALUE))
    else $error("modulo loaded with no boundary selected");
  imm_load_a: assert property (
    (running && ext_en_reg && imm && hw_any && full_w[0]) |=> MOD_VALUE == $past(wbuf_w[0]))
    else $error("immediate modulo load missed");
  mask_free_a: assert property (
    !mask_sync_reg ##1 1 |-> OUT_MASK == $past(mask_buf_reg))
    else $error("mask not following its buffer");
  mask_hold_a: assert property (
    (mask_sync_reg && !mask_evt) |=> OUT_MASK == $past(OUT_MASK))
    else $error("mask changed without trigger");
  wrap_immediate_a_a: assert property (
    (!immediate_a_reg && CNT_WRAP) |=> CNT_IMMEDIATE_A)
    else $error("counter immediate_a missing at wrap");
  flag_clear_a: assert property (
    (ld_w[1] && !wsel_w[1]) |=> !full_w[1])
    else $error("buffer flag not cleared on transfer");
endmodule : pwmbs_sync

// >>> testbench/pwm_timer_buffer_sync_tb_top.sv
// self-checking bench for the pwm timer write-buffer synchronisation block
`timescale 1ns/1ns
module pwm_timer_buffer_sync_tb_top;
  // =========================================
  // signals
  logic         clk = 0, nrst = 0;
  logic [7:0]   awaddr = 0, araddr = 0;
  logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0]  wdata = 0, rdata;
  logic [3:0]   wstrb = 0;
  logic         awready, wready, bvalid, arready, rvalid, immediate_a, center;
  logic [1:0]   bresp, rresp, csrc, r;
  logic [2:0]   trig = 0;
  logic [4:0]   ev = 0;
  logic [15:0]  mod_v, init_v;
  logic [127:0] ch_v;
  logic [7:0]   omask;
  logic [31:0]  v [0:9];
  logic [31:0]  d;
  int           miscompares = 0, tests_run = 0, cycles = 0, reinits = 0, n;
  always #5 clk = ~clk;
  pwmbs_sync dut_u (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TRIG_IN(trig),
    .CNT_TICK(ev[0]), .CNT_WRAP(ev[1]), .CNT_PEAK_STEP(ev[2]), .CNT_MIN_STEP(ev[3]),
    .CNT_MAX_STEP(ev[4]), .MOD_VALUE(mod_v), .INIT_VALUE(init_v), .CH_VALUE(ch_v),
    .OUT_MASK(omask), .CNT_IMMEDIATE_A(immediate_a), .CLK_SOURCE(csrc), .CENTER_MODE(center));
  // =========================================
  // helpers
  always @(posedge clk) begin
    cycles++;
    if (immediate_a === 1'b1) reinits++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // waits on the response only; address and data are released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a; awvalid <= 1; wdata <= dt; wstrb <= s; wvalid <= 1; bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp; bready <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata; r = rresp; rready <= 0;
    #1;
  endtask : rd
  task automatic pulse(input logic [4:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 0;
    #1;
  endtask : pulse
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : idle
  // =========================================
  // main sequence
  initial begin
    d = $urandom(32'heb2b);
    foreach (v[i]) v[i] = {16'h0, 16'($urandom)};
    repeat (20) @(posedge clk);
    nrst <= 1;
    idle(1);
    chk("mod_rst", mod_v, 0);
    chk("mask_rst", omask, 0);
    // stopped clock: half a value never loads
    wr(pwmbs_pkg::OFS_MOD, v[0], 4'h1);
    chk("mod_half", mod_v, 0);
    wr(pwmbs_pkg::OFS_MOD, v[0], 4'h2);
    chk("mod_stop", mod_v, v[0]);
    wr(pwmbs_pkg::OFS_CHV, v[1], 4'h3);
    chk("ch_stop", ch_v[15:0], v[1]);
    wr(pwmbs_pkg::OFS_INIT, v[2], 4'h3);
    chk("init", init_v, v[2]);
    wr(8'h1c, v[2], 4'hf);
    chk("wr_unmapped", r, pwmbs_pkg::RESP_SLVERR);
    rd(8'h1c);
    chk("rd_unmapped", d, 32'h0);
    chk("rd_resp", r, pwmbs_pkg::RESP_SLVERR);
    // running, features off, edge pwm: loads wait for the wrap
    wr(pwmbs_pkg::OFS_CTRL, 32'h1, 4'h1);
    wr(pwmbs_pkg::OFS_MOD, v[3], 4'h3);
    wr(pwmbs_pkg::OFS_CHV, v[4], 4'h3);
    rd(pwmbs_pkg::OFS_STAT);
    chk("stat_full", d[2:0], 3'b101);
    pulse(5'h01);
    chk("mod_tick", mod_v, v[0]);
    chk("ch_tick", ch_v[15:0], v[1]);
    n = reinits;
    pulse(5'h02);
    chk("mod_wrap", mod_v, v[3]);
    chk("ch_wrap", ch_v[15:0], v[4]);
    rd(pwmbs_pkg::OFS_STAT);
    chk("stat_clr", d[2:0], 3'b000);
    chk("immediate_a_wrap", reinits - n, 1);
    // output compare follows the next counter change
    wr(pwmbs_pkg::OFS_CHCFG, 32'h1, 4'h1);
    wr(pwmbs_pkg::OFS_CHV, v[5], 4'h3);
    pulse(5'h01);
    chk("ch_oc", ch_v[15:0], v[5]);
    // features on: modulo only through a software-triggered boundary load
    wr(pwmbs_pkg::OFS_CTRL, 32'h5, 4'h1);
    wr(pwmbs_pkg::OFS_SYNC, 32'h10, 4'h3);
    wr(pwmbs_pkg::OFS_MOD, v[6], 4'h3);
    pulse(5'h02);
    chk("mod_nosync", mod_v, v[3]);
    wr(pwmbs_pkg::OFS_SYNC, 32'h18, 4'h3);
    idle(3);
    rd(pwmbs_pkg::OFS_SYNC);
    chk("swreq_held", d[3], 1'b1);
    pulse(5'h02);
    chk("mod_bnd", mod_v, v[6]);
    rd(pwmbs_pkg::OFS_SYNC);
    chk("swreq_clr", d[5:3], 3'b010);
    // immediate mode with a hardware trigger; the idle trigger keeps its enable
    wr(pwmbs_pkg::OFS_SYNC, 32'h83, 4'h3);
    wr(pwmbs_pkg::OFS_MOD, v[7], 4'h3);
    n = reinits;
    @(posedge clk) trig <= 3'h1;
    idle(6);
    @(posedge clk) trig <= 3'h0;
    chk("mod_hw", mod_v, v[7]);
    chk("immediate_a_hw", reinits - n, 1);
    rd(pwmbs_pkg::OFS_SYNC);
    chk("trig_en", d[2:0], 3'b010);
    // mask follows its buffer, then only on a trigger
    wr(pwmbs_pkg::OFS_SYNC, 32'h0, 4'h3);
    wr(pwmbs_pkg::OFS_MASK, v[8], 4'h1);
    idle(2);
    chk("mask_free", omask, v[8][7:0]);
    wr(pwmbs_pkg::OFS_SYNC, 32'h101, 4'h3);
    wr(pwmbs_pkg::OFS_MASK, v[9], 4'h1);
    idle(2);
    chk("mask_hold", omask, v[8][7:0]);
    @(posedge clk) trig <= 3'h1;
    idle(6);
    chk("mask_trig", omask, v[9][7:0]);
    // trigger event in the same cycle as a write that sets its enable
    wr(pwmbs_pkg::OFS_SYNC, 32'h102, 4'h3);
    wr(pwmbs_pkg::OFS_MASK, v[0], 4'h1);
    @(posedge clk) trig <= 3'h2;
    wr(pwmbs_pkg::OFS_SYNC, 32'h102, 4'h3);
    chk("mask_coinc", omask, v[0][7:0]);
    rd(pwmbs_pkg::OFS_SYNC);
    chk("trig_keep", d[2:0], 3'b010);
    // centre mode, features off: loads wait for the modulo to modulo-1 step
    wr(pwmbs_pkg::OFS_CTRL, 32'h9, 4'h1);
    chk("clk_src", csrc, 2'h1);
    chk("center", center, 1'b1);
    wr(pwmbs_pkg::OFS_CHCFG, 32'h0, 4'h3);
    wr(pwmbs_pkg::OFS_MOD, v[1], 4'h3);
    wr(pwmbs_pkg::OFS_CHV, v[2], 4'h3);
    pulse(5'h02);
    chk("mod_cwrap", mod_v, v[7]);
    pulse(5'h04);
    chk("mod_peak", mod_v, v[1]);
    chk("ch_peak", ch_v[15:0], v[2]);
    // mode 1, maximum boundary, channel sync: only a software request loads
    wr(pwmbs_pkg::OFS_CTRL, 32'hd, 4'h1);
    wr(pwmbs_pkg::OFS_CHCFG, 32'h100, 4'h3);
    wr(pwmbs_pkg::OFS_SYNC, 32'h60, 4'h3);
    wr(pwmbs_pkg::OFS_MOD, v[3], 4'h3);
    wr(pwmbs_pkg::OFS_CHV, v[4], 4'h3);
    pulse(5'h04);
    chk("ch_nosync", ch_v[15:0], v[2]);
    pulse(5'h10);
    chk("mod_nosw", mod_v, v[1]);
    wr(pwmbs_pkg::OFS_SYNC, 32'h68, 4'h3);
    pulse(5'h10);
    chk("mod_max", mod_v, v[3]);
    chk("ch_sync", ch_v[15:0], v[4]);
    rd(pwmbs_pkg::OFS_SYNC);
    chk("swreq_max", d[6:3], 4'b1100);
    // centre mode, minimum boundary: the load waits for initial+1 to initial
    wr(pwmbs_pkg::OFS_SYNC, 32'h18, 4'h3);
    wr(pwmbs_pkg::OFS_MOD, v[5], 4'h3);
    pulse(5'h02);
    chk("mod_minwait", mod_v, v[3]);
    pulse(5'h08);
    chk("mod_min", mod_v, v[5]);
    test_done();
  end
endmodule : pwm_timer_buffer_sync_tb_top
